// File: src/crl_linkage.sv
// Call, return and interrupt linkage sequencer over a word stack
// ----------------------------------------------------------------
// What this block does
// - A call first pushes the linkage register onto the system stack as a predecrement store.
// - After the push the linkage register takes the return address and the PC takes the entry.
// - The PC may be the linkage register, so the return address itself goes onto the stack.
// - A return copies the named register to the PC, then reloads it from the popped top word.
// - Interrupts are taken only between instructions, never in the middle of one.
// - Interrupt entry pushes the status word then the PC, leaving the PC on top.
// - The new PC comes from the first vector word and the new status from the next.
// - The new status word takes effect at once, selecting mode and register set.
// - Interrupt return pops the PC then the status word and resumes the old program.
// - The system stack pointer stays even and moves by whole words only.
// - Calls and interrupts nest in any mixture, each return undoing the latest save.
// - The stack grows downward, the pointer addressing the newest item.
// - Register six is always the hardware stack pointer for linkage.
// ----------------------------------------------------------------
module crl_linkage (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  cmdValid,
  input  wire crl_pkg::crl_cmd_t     cmdOp,
  input  wire logic [2:0]            cmdReg,
  input  wire logic [15:0]           cmdTarget,
  input  wire logic                  irqReq,
  input  wire logic [15:0]           irqVector,
  input  wire logic [15:0]           memRdata,
  output logic                       cmdReady,
  output logic                       irqAck,
  output logic                       memWe,
  output logic                       memRe,
  output logic [15:0]                memAddr,
  output logic [15:0]                memWdata,
  output logic [15:0]                pcOut,
  output logic [15:0]                spOut,
  output logic [15:0]                pswOut,
  output logic                       regSetOut,
  output logic [1:0]                 modeOut,
  output logic [15:0]                linkOut
);
  // ----------------------------------------------------------------
  // State and register file
  // ----------------------------------------------------------------
  crl_pkg::crl_state_t state_q;
  logic [15:0] regs_q [0:7];
  logic [15:0] psw_q;
  logic [2:0]  lnk_q;
  logic [15:0] tgt_q;
  logic        irqSync1_q;
  logic        irqSync2_q;
  logic [15:0] spDec;
  logic [15:0] spInc;

  // Whole-word steps only, so an even pointer can never turn odd
  assign spDec = regs_q[crl_pkg::REG_SP] - crl_pkg::WORD_STEP;
  assign spInc = regs_q[crl_pkg::REG_SP] + crl_pkg::WORD_STEP;

  // Request arrives from a pin, so two flops before use
  always_ff @(posedge clk) begin
    if (rst) begin
      irqSync1_q <= 1'b0;
      irqSync2_q <= 1'b0;
    end else begin
      irqSync1_q <= irqReq;
      irqSync2_q <= irqSync1_q;
    end
  end

  // Idle is the instruction boundary; interrupt wins over a new command
  assign cmdReady = (state_q == crl_pkg::ST_IDLE) && !irqSync2_q;
  assign irqAck   = (state_q == crl_pkg::ST_IDLE) && irqSync2_q;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= crl_pkg::ST_IDLE;
      lnk_q   <= 3'h0;
      tgt_q   <= 16'h0000;
    end else begin
      unique case (state_q)
        crl_pkg::ST_IDLE: begin
          if (irqSync2_q) begin
            state_q <= crl_pkg::ST_IPSHPSW;
            tgt_q   <= irqVector;
          end else if (cmdValid) begin
            lnk_q <= cmdReg;
            tgt_q <= cmdTarget;
            unique case (cmdOp)
              crl_pkg::CMD_CALL: state_q <= crl_pkg::ST_CALLPSH;
              crl_pkg::CMD_RET:  state_q <= crl_pkg::ST_RETPOP;
              crl_pkg::CMD_RTI:  state_q <= crl_pkg::ST_RPOPPC;
              crl_pkg::CMD_NONE: state_q <= crl_pkg::ST_IDLE;
            endcase
          end
        end
        crl_pkg::ST_CALLPSH: state_q <= crl_pkg::ST_IDLE;
        crl_pkg::ST_RETPOP:  state_q <= crl_pkg::ST_IDLE;
        crl_pkg::ST_IPSHPSW: state_q <= crl_pkg::ST_IPSHPC;
        crl_pkg::ST_IPSHPC:  state_q <= crl_pkg::ST_IVECPC;
        crl_pkg::ST_IVECPC:  state_q <= crl_pkg::ST_IVECPSW;
        crl_pkg::ST_IVECPSW: state_q <= crl_pkg::ST_IDLE;
        crl_pkg::ST_RPOPPC:  state_q <= crl_pkg::ST_RPOPPSW;
        crl_pkg::ST_RPOPPSW: state_q <= crl_pkg::ST_IDLE;
        default:             state_q <= crl_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Memory port: stack pushes, pops and vector reads, one per cycle
  // ----------------------------------------------------------------
  always_comb begin
    memWe    = 1'b0;
    memRe    = 1'b0;
    memAddr  = regs_q[crl_pkg::REG_SP];
    memWdata = 16'h0000;
    unique case (state_q)
      crl_pkg::ST_CALLPSH: begin
        memWe    = 1'b1;
        memAddr  = spDec;
        memWdata = regs_q[lnk_q];
      end
      crl_pkg::ST_IPSHPSW: begin
        memWe    = 1'b1;
        memAddr  = spDec;
        memWdata = psw_q;
      end
      crl_pkg::ST_IPSHPC: begin
        memWe    = 1'b1;
        memAddr  = spDec;
        memWdata = regs_q[crl_pkg::REG_PC];
      end
      crl_pkg::ST_IVECPC: begin
        memRe   = 1'b1;
        memAddr = tgt_q;
      end
      crl_pkg::ST_IVECPSW: begin
        memRe   = 1'b1;
        memAddr = tgt_q + crl_pkg::WORD_STEP;
      end
      crl_pkg::ST_RETPOP,
      crl_pkg::ST_RPOPPC,
      crl_pkg::ST_RPOPPSW: memRe = 1'b1;
      default: ;
    endcase
  end

  // ----------------------------------------------------------------
  // Register file updates; read data is combinational same cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        regs_q[i] <= 16'h0000;
      end
      regs_q[crl_pkg::REG_SP] <= crl_pkg::RESET_SP;
    end else begin
      unique case (state_q)
        crl_pkg::ST_CALLPSH: begin
          regs_q[crl_pkg::REG_SP] <= spDec;
          // PC as linkage: stored PC is the return, PC then takes entry
          regs_q[lnk_q] <= regs_q[crl_pkg::REG_PC];
          regs_q[crl_pkg::REG_PC] <= tgt_q;
        end
        crl_pkg::ST_RETPOP: begin
          regs_q[crl_pkg::REG_SP] <= spInc;
          regs_q[crl_pkg::REG_PC] <= regs_q[lnk_q];
          regs_q[lnk_q] <= memRdata;
        end
        crl_pkg::ST_IPSHPSW,
        crl_pkg::ST_IPSHPC: regs_q[crl_pkg::REG_SP] <= spDec;
        crl_pkg::ST_IVECPC:  regs_q[crl_pkg::REG_PC] <= memRdata;
        crl_pkg::ST_RPOPPC: begin
          regs_q[crl_pkg::REG_PC] <= memRdata;
          regs_q[crl_pkg::REG_SP] <= spInc;
        end
        crl_pkg::ST_RPOPPSW: regs_q[crl_pkg::REG_SP] <= spInc;
        default: ;
      endcase
    end
  end

  // Status word is visible as soon as it is loaded
  always_ff @(posedge clk) begin
    if (rst) begin
      psw_q <= crl_pkg::RESET_PSW;
    end else if (state_q == crl_pkg::ST_IVECPSW || state_q == crl_pkg::ST_RPOPPSW) begin
      psw_q <= memRdata;
    end
  end

  assign pcOut     = regs_q[crl_pkg::REG_PC];
  assign spOut     = regs_q[crl_pkg::REG_SP];
  assign pswOut    = psw_q;
  assign modeOut   = psw_q[15:14];
  assign regSetOut = psw_q[11];
  assign linkOut   = regs_q[lnk_q];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence irqEntry_s;
    irqAck ##1 memWe ##1 memWe ##1 memRe ##1 memRe;
  endsequence

  sp_even_a: assert property (@(posedge clk) disable iff (rst)
    spOut[0] == 1'b0) else $error("stack pointer odd");
  push_dec_a: assert property (@(posedge clk) disable iff (rst)
    memWe |-> memAddr == spOut - crl_pkg::WORD_STEP ##1 spOut == $past(memAddr))
    else $error("push did not predecrement");
  pop_inc_a: assert property (@(posedge clk) disable iff (rst)
    (memRe && memAddr == spOut) |=> spOut == $past(spOut) + crl_pkg::WORD_STEP)
    else $error("pop did not postincrement");
  irq_seq_a: assert property (@(posedge clk) disable iff (rst)
    irqAck |-> irqEntry_s) else $error("interrupt entry order wrong");
  irq_pcTop_a: assert property (@(posedge clk) disable iff (rst)
    irqAck |=> ##1 memWdata == pcOut ##2 pcOut == $past(memRdata))
    else $error("vector pc not loaded");
  psw_load_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == crl_pkg::ST_IVECPSW) |=> pswOut == $past(memRdata))
    else $error("status not effective");
  call_link_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == crl_pkg::ST_CALLPSH) |=> pcOut == $past(tgt_q))
    else $error("call did not jump");
  ret_pc_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == crl_pkg::ST_RETPOP && lnk_q != crl_pkg::REG_PC)
      |=> pcOut == $past(linkOut)) else $error("return pc wrong");
  rti_two_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == crl_pkg::ST_RPOPPC) |=> pcOut == $past(memRdata) ##1
      pswOut == $past(memRdata)) else $error("rti restore wrong");
  boundary_a: assert property (@(posedge clk) disable iff (rst)
    irqAck |-> state_q == crl_pkg::ST_IDLE ##1 state_q == crl_pkg::ST_IPSHPSW)
    else $error("irq mid instruction");
endmodule

// File: src/crl_pkg.sv
// Package for the call, return and interrupt linkage sequencer
package crl_pkg;
  // ----------------------------------------------------------------
  // Widths and register numbers
  // ----------------------------------------------------------------
  localparam int          WORD_W    = 16;
  localparam logic [2:0]  REG_SP    = 3'h6;  // System stack pointer
  localparam logic [2:0]  REG_PC    = 3'h7;  // Program counter
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [15:0] RESET_PC  = 16'h0000;
  localparam logic [15:0] RESET_SP  = 16'h1000;
  localparam logic [15:0] RESET_PSW = 16'h0000;

  // ----------------------------------------------------------------
  // Commands and states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CMD_CALL = 2'b00,
    CMD_RET  = 2'b01,
    CMD_RTI  = 2'b10,
    CMD_NONE = 2'b11
  } crl_cmd_t;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0000,
    ST_CALLPSH = 4'b0001,
    ST_RETPOP  = 4'b0010,
    ST_IPSHPSW = 4'b0011,
    ST_IPSHPC  = 4'b0100,
    ST_IVECPC  = 4'b0101,
    ST_IVECPSW = 4'b0110,
    ST_RPOPPC  = 4'b0111,
    ST_RPOPPSW = 4'b1000
  } crl_state_t;
endpackage

// File: test/crl_mem_model.sv
// Stack memory and interrupting peripheral facing the linkage sequencer
module crl_mem_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        memWe,
  input  wire logic        memRe,
  input  wire logic [15:0] memAddr,
  input  wire logic [15:0] memWdata,
  input  wire logic        irqAck,
  input  wire logic        ieSet,
  input  wire logic        doneSet,
  output logic [15:0]      memRdata,
  output logic             irqReq
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Word memory
  // ----------------------------------------------------------------
  logic [15:0] mem [0:8191];
  logic [7:0]  csrQ;
  // Word writes only; the low address bit is dropped
  always @(posedge clk) begin
    if (memWe) begin
      mem[memAddr[13:1]] <= memWdata;
    end
  end
  // Unstrobed reads return a scrambled word so stale data never passes
  assign memRdata = memRe ? mem[memAddr[13:1]] : ~mem[memAddr[13:1]];
  // ----------------------------------------------------------------
  // Peripheral status: bit 7 completion, bit 6 interrupt enable
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      csrQ <= 8'h00;
    end else begin
      csrQ[6] <= ieSet;
      if (doneSet) begin
        csrQ[7] <= 1'b1;
      end else if (irqAck) begin
        csrQ[7] <= 1'b0;
      end
    end
  end
  // Request only while completion and enable both stand
  assign irqReq = csrQ[7] & csrQ[6];
endmodule

// File: test/crl_linkage_tb_top.sv
// Self-checking bench for the call, return and interrupt linkage sequencer
module crl_linkage_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clk, rst, cmdValid, irqReq, irqAck, cmdReady;
  logic              memWe, memRe, regSetOut, ieSet, doneSet;
  logic [2:0]        cmdReg;
  logic [1:0]        modeOut;
  logic [15:0]       cmdTarget, irqVector, memRdata, memAddr, memWdata;
  logic [15:0]       pcOut, spOut, pswOut, linkOut;
  crl_pkg::crl_cmd_t cmdOp;
  int                fails, samplesChecked;
  // ----------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------
  crl_linkage i_crl_linkage (.clk(clk), .rst(rst), .cmdValid(cmdValid), .cmdOp(cmdOp),
    .cmdReg(cmdReg), .cmdTarget(cmdTarget), .irqReq(irqReq), .irqVector(irqVector),
    .memRdata(memRdata), .cmdReady(cmdReady), .irqAck(irqAck), .memWe(memWe), .memRe(memRe),
    .memAddr(memAddr), .memWdata(memWdata), .pcOut(pcOut), .spOut(spOut), .pswOut(pswOut),
    .regSetOut(regSetOut), .modeOut(modeOut), .linkOut(linkOut));
  crl_mem_model i_crl_mem_model (.clk(clk), .rst(rst), .memWe(memWe), .memRe(memRe),
    .memAddr(memAddr), .memWdata(memWdata), .irqAck(irqAck), .ieSet(ieSet),
    .doneSet(doneSet), .memRdata(memRdata), .irqReq(irqReq));
  // Free running clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic step;
    @(posedge clk);
    #10;
  endtask
  task automatic checkWord(input string what, input logic [15:0] exp, input logic [15:0] got);
    samplesChecked++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask
  function automatic logic [15:0] peek(input logic [15:0] a);
    return i_crl_mem_model.mem[a[13:1]];
  endfunction
  // Bounded wait so a stuck sequencer cannot hang the run
  task automatic waitReady;
    int n;
    n = 0;
    while (cmdReady !== 1'b1 && n < 50) begin
      step;
      n++;
    end
    if (cmdReady !== 1'b1) fails++;
  endtask
  task automatic issue(input crl_pkg::crl_cmd_t op, input logic [2:0] r, input logic [15:0] t);
    waitReady;
    cmdOp = op;
    cmdReg = r;
    cmdTarget = t;
    cmdValid = 1'b1;
    step;
    cmdValid = 1'b0;
    waitReady;
  endtask
  task automatic wrapUp;
    $display("checked %0d mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_calls;
    checkWord("reset pc", crl_pkg::RESET_PC, pcOut);
    checkWord("reset sp", crl_pkg::RESET_SP, spOut);
    // An empty command must leave the stack and PC alone
    issue(crl_pkg::CMD_NONE, 3'h5, 16'h0300);
    checkWord("none pc", crl_pkg::RESET_PC, pcOut);
    checkWord("none sp", crl_pkg::RESET_SP, spOut);
    issue(crl_pkg::CMD_CALL, 3'h7, 16'h0100);
    checkWord("pc push", 16'h0000, peek(16'h0FFE));
    issue(crl_pkg::CMD_CALL, 3'h5, 16'h0300);
    checkWord("link push", 16'h0000, peek(16'h0FFC));
    checkWord("link", 16'h0100, linkOut);
    checkWord("pc", 16'h0300, pcOut);
    checkWord("sp", 16'h0FFC, spOut);
    issue(crl_pkg::CMD_RET, 3'h5, 16'h0000);
    checkWord("ret pc", 16'h0100, pcOut);
    checkWord("ret link", 16'h0000, linkOut);
    issue(crl_pkg::CMD_RET, 3'h7, 16'h0000);
    checkWord("ret pc", 16'h0000, pcOut);
    checkWord("ret sp", crl_pkg::RESET_SP, spOut);
    $display("test calls done");
  endtask
  // Done without enable must not be taken; enable then lets it through
  task automatic test_irq;
    int n;
    issue(crl_pkg::CMD_CALL, 3'h7, 16'h0700);
    doneSet = 1'b1;
    step;
    doneSet = 1'b0;
    n = 0;
    repeat (10) begin
      step;
      if (irqAck === 1'b1) n++;
    end
    checkWord("masked ack", 16'h0000, 16'(n));
    ieSet = 1'b1;
    n = 0;
    while (irqAck !== 1'b1 && n < 20) begin
      step;
      n++;
    end
    if (irqAck !== 1'b1) fails++;
    waitReady;
    checkWord("saved psw", crl_pkg::RESET_PSW, peek(16'h0FFC));
    checkWord("saved pc", 16'h0700, peek(16'h0FFA));
    checkWord("vec pc", 16'h0200, pcOut);
    checkWord("vec psw", 16'hC800, pswOut);
    checkWord("mode", 16'h0003, {14'h0000, modeOut});
    checkWord("set", 16'h0001, {15'h0000, regSetOut});
    checkWord("isp", 16'h0FFA, spOut);
    issue(crl_pkg::CMD_CALL, 3'h7, 16'h0500);
    issue(crl_pkg::CMD_RET, 3'h7, 16'h0000);
    checkWord("nest pc", 16'h0200, pcOut);
    issue(crl_pkg::CMD_RTI, 3'h0, 16'h0000);
    checkWord("rti pc", 16'h0700, pcOut);
    checkWord("rti psw", crl_pkg::RESET_PSW, pswOut);
    checkWord("rti sp", 16'h0FFE, spOut);
    $display("test irq done");
  endtask
  // Main sequence
  initial begin
    {rst, cmdValid, ieSet, doneSet} = 4'h8;
    cmdOp = crl_pkg::CMD_NONE;
    {cmdReg, cmdTarget, fails, samplesChecked} = '0;
    irqVector = 16'h0040;
    for (int i = 0; i < 8192; i++) i_crl_mem_model.mem[i] = 16'hFFFF;
    i_crl_mem_model.mem[13'h0020] = 16'h0200;
    i_crl_mem_model.mem[13'h0021] = 16'hC800;
    repeat (16) @(posedge clk);
    #10;
    rst = 1'b0;
    test_calls;
    test_irq;
    wrapUp;
  end
  // Watchdog: about 5000 cycles, far beyond the under a hundred the tests need
  initial begin
    #500000;
    fails++;
    wrapUp;
  end
endmodule
